// ### design/rmc_top.sv
`timescale 1ns/1ps
`default_nettype none
// What this block does
// (RL1) read enable echo only in synchronous read
// (RL2) standard mode: output shows full
// (RL3) prefetch mode: output shows space available
// (RL4) init samples offset selects and access pin
// (RL5) init samples prefetch pin for timing mode
// (RL6) after init prefetch pin is serial input
// (RL7) async read requires standard mode
// (RL8) half flag shows above half capacity
// (RL9) parity placement strap sampled in init
// (RL10) port widths from width straps plus matching
// (RL11) width encoding per matching and straps
// (RL12) access low redirects to offset registers
// (RL13) host keeps access high for array traffic
// (RL14) mark records current read pointer
// (RL15) rewind reloads read pointer from mark
// (RL16) init zeroes pointers and output register
// (RL17) init latches port sync, order, latency, timing
// (RL18) output enable controls outputs directly; after init the code also gates data_oe with read_port_select_n
// (RL19) during reset only output enable matters
// (RL20) almost empty high when count reaches offset
// (RL21) almost full high while free exceeds offset
// (RL22) straps held from init release onward
// (RL23) init clears mark position to zero
module rmc_top
#(
	parameter int DEPTH = 16,
	parameter int DW = 32
)(
	input wire logic clk, // 10 MHz clock
	input wire logic rstn, // sync reset, active low
	input wire logic psel, // apb select
	input wire logic penable, // apb enable
	input wire logic pwrite, // apb direction
	input wire logic [7:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error
	input wire logic full_init_n, // initializing reset pin
	input wire logic prefetch_si, // prefetch strap / serial in
	input wire logic serial_en, // serial offset shift enable
	input wire logic offset_default_sel0, // default offset select
	input wire logic offset_default_sel1, // default offset select
	input wire logic offset_access, // offset register access, low active
	input wire logic parity_placement, // parity strap
	input wire logic write_width_sel, // write width strap
	input wire logic read_width_sel, // read width strap
	input wire logic width_match_en, // width matching strap
	input wire logic read_sync_sel, // read port sync strap
	input wire logic write_sync_sel, // write port sync strap
	input wire logic byte_order, // byte order strap
	input wire logic zero_latency, // zero latency strap
	input wire logic flag_timing_sel, // flag timing strap
	input wire logic mark, // mark read position
	input wire logic rewind, // rewind read pointer
	input wire logic out_enable_n, // data output enable
	input wire logic read_port_select_n, // read chip select
	input wire logic read_enable, // read enable pin
	output logic read_enable_echo, // echoed read enable
	output logic full_indicator, // full or space available
	output logic half_level_flag, // above half capacity
	output logic almost_empty_flag, // count at or over empty offset
	output logic almost_full_flag, // free over full offset
	output logic [DW-1:0] data_out, // output register
	output logic data_oe // data output driven
);
	import rmc_pkg::*;
	localparam int AW = $clog2(DEPTH);
	localparam int NP = 20;
	localparam logic [AW:0] CAP = (AW+1)'(DEPTH);
	localparam logic [AW:0] HALF = (AW+1)'(DEPTH/2);

	// ************
	// pin synchronisers
	// ************
	logic [NP-1:0] pin_raw, pin_s1, pin_s2;
	assign pin_raw = {full_init_n, prefetch_si, serial_en, offset_default_sel0,
		offset_default_sel1, offset_access, parity_placement, write_width_sel,
		read_width_sel, width_match_en, read_sync_sel, write_sync_sel, byte_order,
		zero_latency, flag_timing_sel, mark, rewind, out_enable_n,
		read_port_select_n, read_enable};
	always_ff @(posedge clk)
	begin
		pin_s1 <= rstn ? pin_raw : '0;
		pin_s2 <= rstn ? pin_s1 : '0;
	end
	logic init_n, si, sen, fs0, fs1, acc, par, iw, ow, bm;
	logic rsy, wsy, bo, zl, ft, mk, rw, oen, rcs_n, ren;
	assign {init_n, si, sen, fs0, fs1, acc, par, iw, ow, bm,
		rsy, wsy, bo, zl, ft, mk, rw, oen, rcs_n, ren} = pin_s2;
	logic in_init;
	assign in_init = !rstn || !init_n;

	// ************
	// strap capture
	// ************
	logic prefetch_mode, parity_mode, serial_prog, rd_sync, wr_sync;
	logic be_mode, zl_mode, ft_mode;
	rmc_width_t wr_width, rd_width;
	logic [2:0] def_sel;
	always_ff @(posedge clk)
	begin
		if (in_init) // [RL22]
		begin
			prefetch_mode <= si && rsy; // [RL5] [RL7]
			parity_mode <= par; // [RL9]
			serial_prog <= !acc; // [RL4]
			def_sel <= {acc, fs1, fs0}; // [RL4]
			rd_sync <= rsy; // [RL17]
			wr_sync <= wsy; // [RL17]
			be_mode <= bo; // [RL17]
			zl_mode <= zl; // [RL17]
			ft_mode <= ft; // [RL17]
			if (!bm) // [RL10] [RL11]
			begin
				wr_width <= RMC_W72;
				rd_width <= RMC_W72;
			end
			else
			begin
				unique case ({iw, ow})
					2'b00:
					begin
						wr_width <= RMC_W72;
						rd_width <= RMC_W36;
					end
					2'b01:
					begin
						wr_width <= RMC_W72;
						rd_width <= RMC_W18;
					end
					2'b10:
					begin
						wr_width <= RMC_W36;
						rd_width <= RMC_W72;
					end
					2'b11:
					begin
						wr_width <= RMC_W18;
						rd_width <= RMC_W72;
					end
				endcase
			end
		end
	end

	// ************
	// apb slave, one wait state
	// ************
	logic commit, wr_go, rd_go, mapped;
	assign commit = psel && penable && pready;
	assign wr_go = commit && pwrite;
	assign rd_go = commit && !pwrite;
	assign mapped = paddr == RMC_DATA_ADDR || paddr == RMC_CFG_ADDR ||
		paddr == RMC_STAT_ADDR || paddr == RMC_OFFS_ADDR;
	logic data_wr, data_rd;
	assign data_wr = wr_go && paddr == RMC_DATA_ADDR && !in_init;
	assign data_rd = rd_go && paddr == RMC_DATA_ADDR && !in_init;

	// ************
	// storage and pointers
	// ************
	logic [DW-1:0] mem [DEPTH];
	logic [AW-1:0] wptr, rptr, mark_ptr;
	logic [AW:0] count, free;
	logic full, empty, push, pop, mk_d, rw_d, mk_rise, rw_rise;
	assign full = count == CAP;
	assign empty = count == '0;
	assign free = CAP - count;
	assign push = data_wr && acc && !full; // [RL12] [RL13]
	assign pop = data_rd && acc && !empty; // [RL12] [RL13]
	assign mk_rise = mk && !mk_d;
	assign rw_rise = rw && !rw_d;
	always_ff @(posedge clk)
	begin
		if (push)
			mem[wptr] <= pwdata[DW-1:0];
	end
	always_ff @(posedge clk)
	begin
		mk_d <= in_init ? 1'b0 : mk;
		rw_d <= in_init ? 1'b0 : rw;
	end
	always_ff @(posedge clk)
	begin
		if (in_init)
			wptr <= '0; // [RL16]
		else if (push)
			wptr <= wptr + 1'b1;
	end
	always_ff @(posedge clk)
	begin
		if (in_init)
			rptr <= '0; // [RL16]
		else if (rw_rise)
			rptr <= mark_ptr; // [RL15]
		else if (pop)
			rptr <= rptr + 1'b1;
	end
	always_ff @(posedge clk)
	begin
		if (in_init)
			mark_ptr <= '0; // [RL23]
		else if (mk_rise)
			mark_ptr <= rptr; // [RL14]
	end
	always_ff @(posedge clk)
	begin
		if (in_init)
			count <= '0;
		else if (rw_rise)
			count <= count + {1'b0, rptr - mark_ptr}; // words since mark come back [RL15]
		else if (push && !pop)
			count <= count + 1'b1;
		else if (pop && !push)
			count <= count - 1'b1;
	end
	always_ff @(posedge clk)
	begin
		if (in_init)
			data_out <= '0; // [RL16]
		else if (pop)
			data_out <= mem[rptr];
	end

	// ************
	// offset registers
	// ************
	logic [RMC_OFF_W-1:0] empty_off, full_off;
	logic off_sel;
	always_ff @(posedge clk)
	begin
		if (in_init)
		begin
			empty_off <= RMC_DEF_OFF[{acc, fs1, fs0}]; // [RL4]
			full_off <= RMC_DEF_OFF[{acc, fs1, fs0}]; // [RL4]
			off_sel <= 1'b0;
		end
		else if (serial_prog && sen)
		begin
			{empty_off, full_off} <= {empty_off[RMC_OFF_W-2:0], full_off, si}; // [RL6]
		end
		else if (data_wr && !acc && !serial_prog) // [RL12]
		begin
			if (off_sel)
				full_off <= pwdata[RMC_OFF_W-1:0];
			else
				empty_off <= pwdata[RMC_OFF_W-1:0];
			off_sel <= !off_sel;
		end
		else if (data_rd && !acc) // [RL12]
			off_sel <= !off_sel;
	end

	// ************
	// apb response
	// ************
	logic [31:0] cfg_word, stat_word, offs_word, rd_val;
	always_comb
	begin
		cfg_word = '0;
		cfg_word[RMC_CFG_PREFETCH] = prefetch_mode;
		cfg_word[RMC_CFG_PARITY] = parity_mode;
		cfg_word[RMC_CFG_SERIAL] = serial_prog;
		cfg_word[RMC_CFG_RSYNC] = rd_sync;
		cfg_word[RMC_CFG_WSYNC] = wr_sync;
		cfg_word[RMC_CFG_BYTE] = be_mode;
		cfg_word[RMC_CFG_ZLAT] = zl_mode;
		cfg_word[RMC_CFG_FTIME] = ft_mode;
		cfg_word[RMC_CFG_WW +: 2] = wr_width;
		cfg_word[RMC_CFG_RW +: 2] = rd_width;
		cfg_word[RMC_CFG_SEL +: 3] = def_sel;
		stat_word = 32'(count);
		offs_word = {16'h0000, 8'(full_off), 8'(empty_off)};
		unique case (paddr)
			RMC_DATA_ADDR: rd_val = acc ? 32'(mem[rptr])
				: 32'(off_sel ? full_off : empty_off);
			RMC_CFG_ADDR: rd_val = cfg_word;
			RMC_STAT_ADDR: rd_val = stat_word;
			RMC_OFFS_ADDR: rd_val = offs_word;
			default: rd_val = '0;
		endcase
	end
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= '0;
		end
		else
		begin
			pready <= psel && penable && !pready;
			pslverr <= psel && penable && !pready && !mapped;
			if (psel && penable && !pready && !pwrite)
				prdata <= (paddr == RMC_DATA_ADDR && acc && empty) ? '0 : rd_val;
		end
	end

	// ************
	// flags and pins
	// ************
	always_ff @(posedge clk)
	begin
		if (in_init)
		begin
			full_indicator <= 1'b0;
			half_level_flag <= 1'b0;
			almost_empty_flag <= 1'b0;
			almost_full_flag <= 1'b0;
			read_enable_echo <= 1'b0;
		end
		else
		begin
			full_indicator <= prefetch_mode ? !full : full; // [RL2] [RL3]
			half_level_flag <= count > HALF; // [RL8]
			almost_empty_flag <= 32'(count) >= 32'(empty_off); // [RL20]
			almost_full_flag <= 32'(free) > 32'(full_off); // [RL21]
			read_enable_echo <= rd_sync && ren; // [RL1]
		end
	end
	always_ff @(posedge clk)
	begin
		if (in_init)
			data_oe <= !oen; // [RL18] [RL19]
		else
			data_oe <= !oen && !rcs_n; // [RL18]
	end
endmodule : rmc_top
`default_nettype wire

// ### design/rmc_pkg.sv
`default_nettype none
package rmc_pkg;
	// ************
	// apb map
	// ************
	localparam logic [7:0] RMC_DATA_ADDR = 8'h00;
	localparam logic [7:0] RMC_CFG_ADDR = 8'h04;
	localparam logic [7:0] RMC_STAT_ADDR = 8'h08;
	localparam logic [7:0] RMC_OFFS_ADDR = 8'h0C;
	// ************
	// port width codes
	// ************
	typedef enum logic [1:0] {
		RMC_W72 = 2'b00,
		RMC_W36 = 2'b01,
		RMC_W18 = 2'b10
	} rmc_width_t;
	// ************
	// cfg field positions
	// ************
	localparam int RMC_CFG_PREFETCH = 0;
	localparam int RMC_CFG_PARITY = 1;
	localparam int RMC_CFG_SERIAL = 2;
	localparam int RMC_CFG_RSYNC = 3;
	localparam int RMC_CFG_WSYNC = 4;
	localparam int RMC_CFG_BYTE = 5;
	localparam int RMC_CFG_ZLAT = 6;
	localparam int RMC_CFG_FTIME = 7;
	localparam int RMC_CFG_WW = 8;
	localparam int RMC_CFG_RW = 10;
	localparam int RMC_CFG_SEL = 12;
	// ************
	// default offset table, index {access,sel1,sel0}
	// ************
	localparam int RMC_OFF_W = 8;
	localparam logic [RMC_OFF_W-1:0] RMC_DEF_OFF [8] = '{
		8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08
	};
	localparam logic [RMC_OFF_W-1:0] RMC_OFF_RST = 8'h00;
endpackage : rmc_pkg
`default_nettype wire

// ### tb/rmc_strap_model.sv
`timescale 1ns/1ps
`default_nettype none
module rmc_strap_model (
	input wire logic [12:0] want, // wanted strap word
	input wire logic full_init_n, // init pin
	input wire logic acc, // access level after init
	output logic [12:0] sp // strap pins
);
	always_comb
	begin
		sp = want;
		if (!full_init_n)
		begin
			sp[0] = want[0] & want[3];
		end
		if (!want[10])
		begin
			sp[9:8] = 2'h0;
		end
		if (full_init_n)
		begin
			sp[2] = acc;
		end
	end
endmodule : rmc_strap_model
`default_nettype wire

// ### tb/rmc_chk.sv
`timescale 1ns/1ps
`default_nettype none
module rmc_chk
	import rmc_pkg::*;
#(parameter int DW = 32)(
	input wire logic clk, // clock
	input wire logic rstn, // reset
	input wire logic psel, // apb
	input wire logic penable, // apb
	input wire logic [7:0] paddr, // apb
	input wire logic pready, // apb
	input wire logic pslverr, // apb
	input wire logic full_init_n, // init
	input wire logic out_enable_n, // oe
	input wire logic read_enable, // read enable
	input wire logic read_enable_echo, // echo
	input wire logic half_level_flag, // half
	input wire logic [DW-1:0] data_out, // data
	input wire logic data_oe // driven
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	apb_wait_a: assert property ($rose(penable) && psel |-> !pready ##1 pready)
		else $error("ready not after one wait");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("ready held");
	bad_addr_a: assert property (psel && penable && pready && paddr > RMC_OFFS_ADDR |-> pslverr)
		else $error("unmapped not refused");
	good_addr_a: assert property (psel && pready && paddr[1:0] == 2'h0
		&& paddr <= RMC_OFFS_ADDR |-> !pslverr) else $error("mapped refused");
	init_clear_a: assert property (!full_init_n [*5] |-> data_out == '0 && !half_level_flag)
		else $error("init left state");
	oe_reset_a: assert property ((!full_init_n && $stable(out_enable_n)) [*5]
		|-> data_oe == !out_enable_n) else $error("oe in init");
	oe_off_a: assert property (out_enable_n [*5] |-> !data_oe)
		else $error("driven with oe off");
	echo_idle_a: assert property (!read_enable [*4] |-> !read_enable_echo)
		else $error("echo without enable");
	cover property (pslverr);
	cover property (half_level_flag);
	cover property (read_enable_echo);
endmodule : rmc_chk
bind rmc_top rmc_chk #(.DW(DW)) u_rmc_chk (
	.clk(clk),
	.rstn(rstn),
	.psel(psel),
	.penable(penable),
	.paddr(paddr),
	.pready(pready),
	.pslverr(pslverr),
	.full_init_n(full_init_n),
	.out_enable_n(out_enable_n),
	.read_enable(read_enable),
	.read_enable_echo(read_enable_echo),
	.half_level_flag(half_level_flag),
	.data_out(data_out),
	.data_oe(data_oe)
);
`default_nettype wire

// ### tb/fifo_reset_mode_config_tb.sv
`timescale 1ns/1ps
`default_nettype none
module fifo_reset_mode_config_tb;
	import rmc_pkg::*;
	localparam int D = 16;
	logic clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, full_init_n = 0, serial_en = 0;
	logic mark = 0, rewind = 0, out_enable_n = 0, read_port_select_n = 0, read_enable = 0;
	logic acc = 1, e;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, q;
	logic [12:0] want = 13'h0;
	wire logic [12:0] sp;
	wire logic [31:0] prdata, data_out;
	wire logic pready, pslverr, read_enable_echo, full_indicator, half_level_flag;
	wire logic almost_empty_flag, almost_full_flag, data_oe;
	wire logic prefetch_si, parity_placement, offset_access, read_sync_sel, write_sync_sel;
	wire logic byte_order, zero_latency, flag_timing_sel, write_width_sel, read_width_sel;
	wire logic width_match_en, offset_default_sel0, offset_default_sel1;
	int n_fail = 0, comparisons = 0, cyc = 0;
	assign {offset_default_sel1, offset_default_sel0, width_match_en, read_width_sel,
		write_width_sel, flag_timing_sel, zero_latency, byte_order, write_sync_sel,
		read_sync_sel, offset_access, parity_placement, prefetch_si} = sp;
	rmc_strap_model u_rmc_strap_model (
		.want(want),
		.full_init_n(full_init_n),
		.acc(acc),
		.sp(sp)
	);
	rmc_top #(.DEPTH(D)) u_rmc_top (
		.clk(clk),
		.rstn(rstn),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.full_init_n(full_init_n),
		.prefetch_si(prefetch_si),
		.serial_en(serial_en),
		.offset_default_sel0(offset_default_sel0),
		.offset_default_sel1(offset_default_sel1),
		.offset_access(offset_access),
		.parity_placement(parity_placement),
		.write_width_sel(write_width_sel),
		.read_width_sel(read_width_sel),
		.width_match_en(width_match_en),
		.read_sync_sel(read_sync_sel),
		.write_sync_sel(write_sync_sel),
		.byte_order(byte_order),
		.zero_latency(zero_latency),
		.flag_timing_sel(flag_timing_sel),
		.mark(mark),
		.rewind(rewind),
		.out_enable_n(out_enable_n),
		.read_port_select_n(read_port_select_n),
		.read_enable(read_enable),
		.read_enable_echo(read_enable_echo),
		.full_indicator(full_indicator),
		.half_level_flag(half_level_flag),
		.almost_empty_flag(almost_empty_flag),
		.almost_full_flag(almost_full_flag),
		.data_out(data_out),
		.data_oe(data_oe)
	);
	// ************
	// clock and timeout
	// ************
	initial
	begin
		forever #50 clk = ~clk;
	end
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 30000)
		begin
			n_fail++;
			test_done();
		end
	end
	function automatic logic [31:0] exp_cfg(logic [12:0] s);
		logic [1:0] w, r;
		w = (s[10] && s[8]) ? (s[9] ? 2'h2 : 2'h1) : 2'h0;
		r = (s[10] && !s[8]) ? (s[9] ? 2'h2 : 2'h1) : 2'h0;
		return {17'h0, s[2], s[12], s[11], r, w, s[7:3], !s[2], s[1], s[0] & s[3]};
	endfunction : exp_cfg
	function automatic logic [7:0] offv(logic [12:0] s);
		return RMC_DEF_OFF[{s[2], s[12], s[11]}];
	endfunction : offv
	task automatic chk(input string n, input logic [31:0] x, input logic [31:0] s);
		comparisons++;
		if (s !== x)
		begin
			n_fail++;
			$display("MISMATCH %s exp %h got %h", n, x, s);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1;
		do @(posedge clk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 0;
		penable <= 0;
	endtask : apb
	task automatic init(input logic [12:0] s);
		@(posedge clk);
		want <= s;
		full_init_n <= 0;
		repeat (6) @(posedge clk);
		full_init_n <= 1;
		repeat (4) @(posedge clk);
	endtask : init
	task automatic pulse(input bit r);
		@(posedge clk);
		if (r) rewind <= 1; else mark <= 1;
		repeat (4) @(posedge clk);
		rewind <= 0;
		mark <= 0;
		repeat (4) @(posedge clk);
	endtask : pulse
	task automatic test_done;
		$display("fails %0d of %0d", n_fail, comparisons);
		if (n_fail == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : test_done
	initial
	begin
		logic [12:0] s;
		logic [31:0] w[$];
		logic [15:0] v;
		void'($urandom(12));
		repeat (20) @(posedge clk);
		rstn <= 1;
		for (int i = 0; i < 12; i++)
		begin
			s = 13'($urandom);
			if (i < 5)
				s[10:8] = {i > 0, i == 2 || i == 4, i > 2};
			init(s);
			chk("dout", 32'h0, data_out);
			apb(0, RMC_CFG_ADDR, 0);
			chk("cfg", exp_cfg(s), q);
			apb(0, RMC_OFFS_ADDR, 0);
			chk("offs", {16'h0, offv(s), offv(s)}, q);
			apb(0, RMC_STAT_ADDR, 0);
			chk("count", 32'h0, q);
			want <= 13'($urandom);
			read_enable <= 1'($urandom);
			out_enable_n <= 1'($urandom);
			read_port_select_n <= 1'($urandom);
			apb(0, RMC_CFG_ADDR, 0);
			chk("held", exp_cfg(s), q);
			chk("echo", s[3] & read_enable, read_enable_echo);
			chk("oe", !out_enable_n && !read_port_select_n, data_oe);
		end
		for (int m = 0; m < 2; m++)
		begin
			s = 13'($urandom);
			s[3:2] = 2'h3;
			s[0] = m;
			init(s);
			w.delete();
			for (int k = 0; k <= D; k++)
			begin
				repeat (2) @(posedge clk);
				chk("full", m ? k < D : k == D, full_indicator);
				chk("half", k > D / 2, half_level_flag);
				chk("ae", k >= offv(s), almost_empty_flag);
				chk("af", D - k > offv(s), almost_full_flag);
				w.push_back($urandom);
				apb(1, RMC_DATA_ADDR, w[k]);
			end
			apb(0, RMC_STAT_ADDR, 0);
			chk("count", D, q);
			foreach (w[k])
			begin
				if (k == 2) pulse(1);
				if (k == 5) pulse(0);
				if (k == 7) pulse(1);
				apb(0, RMC_DATA_ADDR, 0);
				chk("pop", w[k < 2 ? k : k < 5 ? k - 2 : k < 7 ? k - 2 : k - 4], q);
				if (k == 9) break;
			end
			acc <= 0;
			apb(1, RMC_DATA_ADDR, 32'h3);
			apb(1, RMC_DATA_ADDR, 32'hB);
			apb(0, RMC_OFFS_ADDR, 0);
			chk("load", 32'h0B03, q);
			acc <= 1;
		end
		s = 13'($urandom);
		s[2] = 1'b0;
		init(s);
		v = 16'($urandom);
		for (int b = 15; b >= 0; b--)
		begin
			@(posedge clk);
			serial_en <= 1'b1;
			want[0] <= v[b];
		end
		@(posedge clk);
		serial_en <= 1'b0;
		apb(0, RMC_OFFS_ADDR, 0);
		chk("serial", {16'h0, v[7:0], v[15:8]}, q);
		apb(1, 8'h10, 32'h1);
		chk("err", 32'h1, e);
		test_done();
	end
endmodule : fifo_reset_mode_config_tb
`default_nettype wire
